// ### logic/port_irq_core.sv
// Purpose: 8-bit port with output latch, change detection and interrupt capture.
// Assumes: A serial front end on this clock presents single-cycle register
//          read and write strobes with an offset and a data byte.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none

module port_irq_core (
    // Clock and reset.
    input  wire logic       clk_sys_i,
    input  wire logic       sys_rst_i,
    // Register port from the serial front end.
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Port pins, split into level, drive and enable.
    input  wire logic [7:0] pin_in_i,
    output logic      [7:0] pin_out_o,
    output logic      [7:0] pin_oe_o,
    output logic      [7:0] pullup_en_o,
    // Interrupt pin.
    output logic            irq_out_o,
    output logic            irq_oe_o
);

    // ************************************************************
    // Storage.
    // ************************************************************
    logic [7:0]           direction_q;
    logic [7:0]           pin_irq_enable_q;
    logic [7:0]           compare_bits_q;
    logic [7:0]           compare_select_q;
    logic [7:0]           device_config_q;
    logic [7:0]           pullup_q;
    logic [7:0]           irq_flags_q;
    logic [7:0]           capture_reg_q;
    logic [7:0]           latch_reg_q;
    logic [7:0]           ref_level_q;
    port_pkg::irq_state_t state_q;
    logic [7:0]           pin_sync;
    logic [7:0]           cond;
    logic                 pending;
    logic                 clr_read;
    logic                 fire;
    logic                 open_drain_sel;
    logic                 irq_polarity;

    // Offset match; used by every decode below.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // ************************************************************
    // Pin sampling.
    // ************************************************************

    // Pins are asynchronous, so detection sees only resynchronised levels.
    pin_sync #(
        .W         (port_pkg::PORT_W)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (pin_in_i),
        .sync_o    (pin_sync)                                   // [RQ23]
    );

    // ************************************************************
    // Configuration registers.
    // ************************************************************

    // Plain read-write settings; config bits 0, 6 and 7 are masked off.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            direction_q      <= port_pkg::RST_DIRECTION;
            pin_irq_enable_q <= port_pkg::RST_ZERO;
            compare_bits_q   <= port_pkg::RST_ZERO;
            compare_select_q <= port_pkg::RST_ZERO;
            device_config_q  <= port_pkg::RST_ZERO;
            pullup_q         <= port_pkg::RST_ZERO;
        end else if (reg_wr_i) begin
            if (hit(reg_addr_i, port_pkg::OFS_DIRECTION)) begin
                direction_q <= reg_wdata_i;
            end else if (hit(reg_addr_i, port_pkg::OFS_IRQ_EN)) begin
                pin_irq_enable_q <= reg_wdata_i;
            end else if (hit(reg_addr_i, port_pkg::OFS_CMP_BITS)) begin
                compare_bits_q <= reg_wdata_i;
            end else if (hit(reg_addr_i, port_pkg::OFS_CMP_SEL)) begin
                compare_select_q <= reg_wdata_i;
            end else if (hit(reg_addr_i, port_pkg::OFS_CONFIG)) begin
                device_config_q <= reg_wdata_i & port_pkg::CFG_MASK;
            end else if (hit(reg_addr_i, port_pkg::OFS_PULLUP)) begin
                pullup_q <= reg_wdata_i;
            end
        end
    end

    // ************************************************************
    // Output latch.
    // ************************************************************

    // Port and latch offsets share one store; there is no port copy.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            latch_reg_q <= port_pkg::RST_ZERO;
        end else if (reg_wr_i && (hit(reg_addr_i, port_pkg::OFS_PORT) ||
                                  hit(reg_addr_i, port_pkg::OFS_LATCH))) begin
            latch_reg_q <= reg_wdata_i;                         // [RQ5] [RQ7]
        end
    end

    // Latch drives only pins whose direction bit is zero.
    assign pin_out_o   = latch_reg_q;
    assign pin_oe_o    = ~direction_q;                          // [RQ7]
    assign pullup_en_o = pullup_q & direction_q;

    // ************************************************************
    // Change detection.
    // ************************************************************

    // Per pin: enabled input only, compared against a bit or the reference.
    for (genvar g = 0; g < 8; g++) begin : g_cond
        always_comb begin
            cond[g] = pin_irq_enable_q[g] & direction_q[g] &     // [RQ9] [RQ10]
                      (compare_select_q[g] ?                    // [RQ19]
                       (pin_sync[g] != compare_bits_q[g]) :     // [RQ16]
                       (pin_sync[g] != ref_level_q[g]));        // [RQ14]
        end
    end

    // A read of capture or port clears; writes there clear nothing.
    assign clr_read = reg_rd_i && (hit(reg_addr_i, port_pkg::OFS_CAPTURE) ||
                                   hit(reg_addr_i, port_pkg::OFS_PORT)); // [RQ12]
    assign pending  = (state_q == port_pkg::IRQ_PENDING);

    // New event wins over a clearing read in the same cycle, so a
    // persisting compare mismatch re-raises at once.
    assign fire = (|cond) && (!pending || clr_read);           // [RQ13] [RQ17]

    // Reference follows the pin unless a pending event holds it, and is
    // reloaded with the new level when an interrupt fires.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ref_level_q <= port_pkg::RST_ZERO;
        end else if (fire) begin
            ref_level_q <= pin_sync;                            // [RQ15]
        end else if (!pending) begin
            ref_level_q <= pin_sync;
        end
    end

    // ************************************************************
    // Interrupt state and capture.
    // ************************************************************

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= port_pkg::IRQ_IDLE;
        end else begin
            case (state_q)
                port_pkg::IRQ_IDLE: begin
                    if (fire) begin
                        state_q <= port_pkg::IRQ_PENDING;
                    end
                end
                port_pkg::IRQ_PENDING: begin
                    if (clr_read && !fire) begin
                        state_q <= port_pkg::IRQ_IDLE;          // [RQ11]
                    end
                end
                default: begin
                    state_q <= port_pkg::IRQ_IDLE;
                end
            endcase
        end
    end

    // Whole port is snapshotted only on the raising event.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            capture_reg_q <= port_pkg::RST_ZERO;
        end else if (fire) begin
            capture_reg_q <= pin_sync;                          // [RQ1] [RQ2] [RQ3]
        end
    end

    // Flags keep collecting conditions while capture is frozen.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_flags_q <= port_pkg::RST_ZERO;
        end else if (clr_read) begin
            irq_flags_q <= cond;                                // [RQ22]
        end else begin
            irq_flags_q <= irq_flags_q | cond;                  // [RQ22]
        end
    end

    // ************************************************************
    // Interrupt pin driver.
    // ************************************************************

    // Open drain pulls low only while pending; push-pull always drives.
    assign open_drain_sel = device_config_q[port_pkg::CFG_OPEN_DRAIN];
    assign irq_polarity   = device_config_q[port_pkg::CFG_POLARITY];

    always_comb begin
        if (open_drain_sel) begin
            irq_out_o = 1'b0;                                   // [RQ20]
            irq_oe_o  = pending;                                // [RQ8]
        end else begin
            irq_out_o = irq_polarity ? pending : !pending;      // [RQ21] [RQ18]
            irq_oe_o  = 1'b1;
        end
    end

    // ************************************************************
    // Read data.
    // ************************************************************

    // Unmapped offsets read zero. Port reads live pins, latch the store.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= port_pkg::RST_ZERO;
        end else if (reg_rd_i) begin
            if (hit(reg_addr_i, port_pkg::OFS_DIRECTION)) begin
                reg_rdata_o <= direction_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_IRQ_EN)) begin
                reg_rdata_o <= pin_irq_enable_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_CMP_BITS)) begin
                reg_rdata_o <= compare_bits_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_CMP_SEL)) begin
                reg_rdata_o <= compare_select_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_CONFIG)) begin
                reg_rdata_o <= device_config_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_PULLUP)) begin
                reg_rdata_o <= pullup_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_FLAGS)) begin
                reg_rdata_o <= irq_flags_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_CAPTURE)) begin
                reg_rdata_o <= capture_reg_q;
            end else if (hit(reg_addr_i, port_pkg::OFS_PORT)) begin
                reg_rdata_o <= pin_sync;                        // [RQ4]
            end else if (hit(reg_addr_i, port_pkg::OFS_LATCH)) begin
                reg_rdata_o <= latch_reg_q;                     // [RQ6]
            end else begin
                reg_rdata_o <= port_pkg::RST_ZERO;
            end
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    // A fired event, with the interrupt pending on the next cycle.
    sequence s_raised;
        fire ##1 pending;
    endsequence

    sequence s_quiet_hold;
        pending && !clr_read;
    endsequence

    property p_capture_load;
        fire |=> capture_reg_q == $past(pin_sync);
    endproperty
    a_capture_load: assert property (p_capture_load) // [RQ1]
        else $error("capture not loaded with port value");

    property p_capture_hold;
        s_quiet_hold |=> $stable(capture_reg_q);
    endproperty
    a_capture_hold: assert property (p_capture_hold) // [RQ2]
        else $error("capture changed while pending");

    property p_port_read;
        reg_rd_i && reg_addr_i == port_pkg::OFS_PORT
            |=> reg_rdata_o == $past(pin_sync);
    endproperty
    a_port_read: assert property (p_port_read) // [RQ4]
        else $error("port read did not return pins");

    property p_latch_write;
        reg_wr_i && (reg_addr_i == port_pkg::OFS_PORT ||
                     reg_addr_i == port_pkg::OFS_LATCH)
            |=> latch_reg_q == $past(reg_wdata_i);
    endproperty
    a_latch_write: assert property (p_latch_write) // [RQ5]
        else $error("latch not written");

    property p_latch_read;
        reg_rd_i && reg_addr_i == port_pkg::OFS_LATCH
            |=> reg_rdata_o == $past(latch_reg_q);
    endproperty
    a_latch_read: assert property (p_latch_read) // [RQ6]
        else $error("latch read wrong");

    property p_irq_push_pull;
        !open_drain_sel |-> irq_oe_o && (irq_out_o == (pending == irq_polarity));
    endproperty
    a_irq_push_pull: assert property (p_irq_push_pull) // [RQ21]
        else $error("push-pull level wrong");

    property p_irq_open_drain;
        open_drain_sel |-> !irq_out_o && (irq_oe_o == pending);
    endproperty
    a_irq_open_drain: assert property (p_irq_open_drain) // [RQ20]
        else $error("open-drain drive wrong");

    property p_outputs_silent;
        (direction_q == 8'h00) && !pending |=> !pending;
    endproperty
    a_outputs_silent: assert property (p_outputs_silent) // [RQ10]
        else $error("output pins raised interrupt");

    property p_write_keeps;
        s_quiet_hold ##0 reg_wr_i |=> pending;
    endproperty
    a_write_keeps: assert property (p_write_keeps) // [RQ12]
        else $error("write cleared interrupt");

    // The pin must show the active level once the event has settled.
    property p_raise_drives;
        s_raised |-> (open_drain_sel ? irq_oe_o : (irq_out_o == irq_polarity));
    endproperty
    a_raise_drives: assert property (p_raise_drives) // [RQ8]
        else $error("interrupt pin not active after event");

    property p_clear_read;
        pending && clr_read && !(|cond) |=> !pending;
    endproperty
    a_clear_read: assert property (p_clear_read) // [RQ11]
        else $error("read did not clear interrupt");

    property p_compare_persist;
        pending && clr_read && |(cond & compare_select_q) |=> pending;
    endproperty
    a_compare_persist: assert property (p_compare_persist) // [RQ17]
        else $error("mismatch lost on clearing read");

    property p_ref_update;
        fire |=> ref_level_q == $past(pin_sync);
    endproperty
    a_ref_update: assert property (p_ref_update) // [RQ15]
        else $error("reference not reloaded");

    property p_flags_collect;
        |cond |=> (irq_flags_q & $past(cond)) == $past(cond);
    endproperty
    a_flags_collect: assert property (p_flags_collect) // [RQ22]
        else $error("flag not set for condition");

endmodule : port_irq_core
`default_nettype wire

// ### logic/port_pkg.sv
// Purpose: Shared constants for the port latch and change interrupt block.
// Assumes: Registers are 8 bits wide and addressed by an 8-bit offset.
// Notes:   Offsets, field positions and reset values live here only.
//
// Function
// [RQ1] Load capture register with whole port value when interrupt is raised, only then.
// [RQ2] Capture stays frozen until a read of capture or port register clears it.
// [RQ3] Each capture bit holds its pin level at interrupt time, one meaning high.
// [RQ4] Port register read returns present sampled pin levels, not the latch.
// [RQ5] Port register write is not stored itself; it updates the output latch.
// [RQ6] Output latch read returns the stored latch byte, not the pin levels.
// [RQ7] Latch writes change stored bits, which drive only pins set as outputs.
// [RQ8] Interrupt pin asserts whenever the internal logic flags an interrupt.
// [RQ9] A pin joins change detection only when its enable bit is set.
// [RQ10] Output pins never cause or influence the interrupt output.
// [RQ11] A raised interrupt stays until capture or port register is read.
// [RQ12] Master writes to capture or port register leave pending interrupt unchanged.
// [RQ13] While pending, new conditions raise nothing and do not overwrite capture.
// [RQ14] Previous-value mode fires when an enabled input leaves its reference level.
// [RQ15] Previous-value mode replaces the reference with the new level after interrupt.
// [RQ16] Compare mode fires whenever an enabled input differs from its compare bit.
// [RQ17] Compare-mode condition persists while mismatch remains, even after clearing read.
// [RQ18] Interrupt driver is open-drain or push-pull with selectable active level.
// [RQ19] Compare-select one compares to compare bit; zero compares to previous value.
// [RQ20] Open-drain bit 2 set makes interrupt open-drain and ignores polarity.
// [RQ21] Push-pull polarity bit 1: one active-high, zero active-low.
// [RQ22] Read-only flag register marks enabled pins with a condition, even after capture.
// [RQ23] Input pin levels are synchronised before detection or capture.

package port_pkg;

    // ************************************************************
    // Widths.
    // ************************************************************
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 8;

    // ************************************************************
    // Register offsets.
    // ************************************************************
    localparam logic [7:0] OFS_DIRECTION = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h02;
    localparam logic [7:0] OFS_CMP_BITS  = 8'h03;
    localparam logic [7:0] OFS_CMP_SEL   = 8'h04;
    localparam logic [7:0] OFS_CONFIG    = 8'h05;
    localparam logic [7:0] OFS_PULLUP    = 8'h06;
    localparam logic [7:0] OFS_FLAGS     = 8'h07;
    localparam logic [7:0] OFS_CAPTURE   = 8'h08;
    localparam logic [7:0] OFS_PORT      = 8'h09;
    localparam logic [7:0] OFS_LATCH     = 8'h0a;

    // ************************************************************
    // Configuration fields and reset values.
    // ************************************************************
    localparam int unsigned CFG_OPEN_DRAIN = 2;
    localparam int unsigned CFG_POLARITY   = 1;
    localparam logic [7:0]  CFG_MASK       = 8'h3e;
    localparam logic [7:0]  RST_DIRECTION  = 8'hff;
    localparam logic [7:0]  RST_ZERO       = 8'h00;

    // Interrupt state, one-hot.
    typedef enum logic [1:0] {
        IRQ_IDLE    = 2'b01,
        IRQ_PENDING = 2'b10
    } irq_state_t;

endpackage : port_pkg

// ### logic/pin_sync.sv
// Purpose: Two-flop synchroniser for a bank of asynchronous pins.
// Assumes: Each bit is independent; no bus coherence is promised.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int unsigned W = 8
) (
    // Clock and reset.
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    // Pins in, synchronised levels out.
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // One pair of flops per bit; bits never mix before the second stage.
    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
                meta_q[g] <= 1'b0;
                sync_o[g] <= 1'b0;
            end else begin
                meta_q[g] <= async_i[g];
                sync_o[g] <= meta_q[g];
            end
        end
    end

endmodule : pin_sync
`default_nettype wire

// ### logic/port_pkg_end_marker_unused.sv
`timescale 1ns/100ps

// ### verif/reg_master_model.sv
// Purpose: Serial front end stand-in that issues single-byte register strobes.
// Assumes: Strobes are taken on the rising edge; read data is valid one cycle later.
// Notes:   Idle address and data show the inverse of the last value, never stale data.
`timescale 1ns/100ps
`default_nettype none

module reg_master_model (
    // Clock.
    input  wire logic       clk_sys_i,
    // Strobes toward the block.
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o,
    // Answer from the block.
    input  wire logic [7:0] reg_rdata_i
);
    // Start idle so no strobe is seen during reset.
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // One write strobe, held across exactly one rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : wr

    // One read strobe; data is taken half a cycle after the taking edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
        d          = reg_rdata_i;
    endtask : rd
endmodule : reg_master_model
`default_nettype wire

// ### verif/port_latch_and_change_interrupt_tb_top.sv
// Purpose: Self-checking bench for the port latch and change interrupt core.
// Assumes: Pins read back the driven latch where enabled, else the bench level.
// Notes:   Waits of five cycles cover the two-flop synchroniser plus capture.
`timescale 1ns/100ps
`default_nettype none

module port_latch_and_change_interrupt_tb_top;
    logic       clk_sys_i;
    logic       sys_rst_i;
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic       irq_out;
    logic       irq_oe;
    logic [7:0] pull_en;
    logic [7:0] ext;
    logic [7:0] cfg;
    int         n_mismatch = 0;
    int         checked    = 0;
    int         cycles     = 0;

    // Driven pins show the latch; the rest follow the bench.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

    reg_master_model m (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

    port_irq_core dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pullup_en_o(pull_en),
        .irq_out_o(irq_out), .irq_oe_o(irq_oe));

    // ****************************************
    // Clock, timeout and checking helpers.
    // ****************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        m.rd(a, d);
        chk("rdata", e, d);
    endtask : rchk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    // Expected enable and level: open-drain drives low only when active.
    function automatic logic [1:0] irq_exp(input logic [7:0] c, input logic act);
        if (c[port_pkg::CFG_OPEN_DRAIN]) begin
            return {act, 1'b0};
        end
        return {1'b1, ~(act ^ c[port_pkg::CFG_POLARITY])};
    endfunction : irq_exp

    // The level is only meaningful while the pin is driven.
    task automatic irq_chk(input logic act);
        logic [1:0] e;
        e = irq_exp(cfg, act);
        chk("irq_oe", {7'h00, e[1]}, {7'h00, irq_oe});
        if (e[1]) begin
            chk("irq_out", {7'h00, e[0]}, {7'h00, irq_out});
        end
    endtask : irq_chk

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        logic [7:0] d;
        logic [7:0] dir;
        logic [7:0] cap;
        int         b;
        int         c;
        ext       = 8'h00;
        cfg       = 8'h00;
        sys_rst_i = 1'b1;
        d         = 8'($urandom(32'haf42));
        repeat (20) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        rchk(port_pkg::OFS_LATCH, port_pkg::RST_ZERO);
        rchk(port_pkg::OFS_PORT, ext);
        rchk(8'h1f, 8'h00);
        irq_chk(1'b0);
        // Random latch, direction and pin levels; mixed pins read back per direction.
        for (int i = 0; i < 4; i++) begin
            d   = 8'($urandom);
            dir = 8'($urandom);
            m.wr(port_pkg::OFS_PORT, d);
            rchk(port_pkg::OFS_LATCH, d);
            m.wr(port_pkg::OFS_PULLUP, d);
            m.wr(port_pkg::OFS_DIRECTION, dir);
            ext = 8'($urandom);
            cyc(3);
            chk("pin_oe", ~dir, pin_oe);
            chk("pin_out", d, pin_out);
            chk("pullup_en", d & dir, pull_en);
            rchk(port_pkg::OFS_PORT, (~dir & d) | (dir & ext));
        end
        // Previous-value mode: disabled pins stay quiet, then a single flip fires.
        m.wr(port_pkg::OFS_DIRECTION, 8'hff);
        m.wr(port_pkg::OFS_CMP_SEL, 8'h00);
        ext = ~ext;
        cyc(5);
        irq_chk(1'b0);
        m.wr(port_pkg::OFS_IRQ_EN, 8'hff);
        b = $urandom_range(7, 0);
        c = (b + 1) % 8;
        ext[b] = ~ext[b];
        cap = ext;
        cyc(5);
        irq_chk(1'b1);
        m.wr(port_pkg::OFS_CAPTURE, 8'h00);
        m.wr(port_pkg::OFS_PORT, 8'h00);
        irq_chk(1'b1);
        ext[c] = ~ext[c];
        cyc(5);
        rchk(port_pkg::OFS_FLAGS, (8'h01 << b) | (8'h01 << c));
        rchk(port_pkg::OFS_CAPTURE, cap);
        cyc(3);
        irq_chk(1'b1);
        rchk(port_pkg::OFS_PORT, ext);
        cyc(3);
        irq_chk(1'b0);
        // Compare mode under every driver setting.
        // Compare bits first, so the mode switch meets no stale mismatch.
        m.wr(port_pkg::OFS_CMP_BITS, ext);
        m.wr(port_pkg::OFS_CMP_SEL, 8'hff);
        for (int k = 0; k < 4; k++) begin
            cfg = 8'(k << 1);
            m.wr(port_pkg::OFS_CONFIG, cfg);
            rchk(port_pkg::OFS_CONFIG, cfg);
            irq_chk(1'b0);
            m.wr(port_pkg::OFS_CMP_BITS, ext ^ (8'h01 << k));
            cyc(3);
            irq_chk(1'b1);
            rchk(port_pkg::OFS_PORT, ext);
            cyc(3);
            irq_chk(1'b1);
            m.wr(port_pkg::OFS_CMP_BITS, ext);
            rchk(port_pkg::OFS_CAPTURE, ext);
            cyc(3);
            irq_chk(1'b0);
        end
        // Output pins mismatch the compare bits yet never interrupt.
        m.wr(port_pkg::OFS_DIRECTION, 8'h00);
        m.wr(port_pkg::OFS_LATCH, ~ext);
        cyc(5);
        chk("pin_out", ~ext, pin_out);
        irq_chk(1'b0);
        tally_and_finish();
    end
endmodule : port_latch_and_change_interrupt_tb_top
`default_nettype wire
